// >>> ufb_pkg.sv
/*
  ufb_pkg: shared constants for the serial port flag, bit-rate, data window,
  dma trigger and transmit peek register block.
  assumes: a 32-bit avalon-mm slave with byte addresses inside a 64-byte
  window; one peripheral clock; fifo depth of 32 bytes each way.
*/
package ufb_pkg;

  // fifo geometry
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned PTR_W      = 5;
  localparam int unsigned CNT_W      = 6;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE       = 6'h01;

  // bus geometry
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned WORD_W = 32;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_THRESH    = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_INT_EN    = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_INT_FL    = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_BAUD_INT  = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_BAUD_FRAC = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_DATA      = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_DMA       = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_PEEK      = 6'h24;

  // interrupt flag bit positions
  localparam int unsigned FL_W          = 10;
  localparam int unsigned FL_FRAME      = 0;
  localparam int unsigned FL_PARITY     = 1;
  localparam int unsigned FL_CTS        = 2;
  localparam int unsigned FL_RX_OVR     = 3;
  localparam int unsigned FL_RX_LVL     = 4;
  localparam int unsigned FL_TX_AE      = 5;
  localparam int unsigned FL_TX_LVL     = 6;
  localparam int unsigned FL_BREAK      = 7;
  localparam int unsigned FL_RECEIVE_TIMEOUT_FLAG      = 8;
  localparam int unsigned FL_LAST_BREAK = 9;
  localparam logic [FL_W-1:0] FL_RESET  = 10'h000;

  // bit-rate fields
  localparam int unsigned BAUD_W      = 12;
  localparam int unsigned BAUD_LSB    = 0;
  localparam int unsigned CLKDIV_W    = 3;
  localparam int unsigned CLKDIV_LSB  = 16;
  localparam logic [BAUD_W-1:0]   BAUD_RESET   = 12'h000;
  localparam logic [CLKDIV_W-1:0] CLKDIV_RESET = 3'h0;

  // prescaler codes and their reload values (divide minus one)
  localparam int unsigned PRE_W = 7;
  localparam logic [CLKDIV_W-1:0] CLKDIV_128 = 3'h0;
  localparam logic [CLKDIV_W-1:0] CLKDIV_64  = 3'h1;
  localparam logic [CLKDIV_W-1:0] CLKDIV_32  = 3'h2;
  localparam logic [CLKDIV_W-1:0] CLKDIV_16  = 3'h3;
  localparam logic [CLKDIV_W-1:0] CLKDIV_8   = 3'h4;
  localparam logic [PRE_W-1:0] PRE_128_M1 = 7'h7F;
  localparam logic [PRE_W-1:0] PRE_64_M1  = 7'h3F;
  localparam logic [PRE_W-1:0] PRE_32_M1  = 7'h1F;
  localparam logic [PRE_W-1:0] PRE_16_M1  = 7'h0F;
  localparam logic [PRE_W-1:0] PRE_8_M1   = 7'h07;
  localparam logic [PRE_W-1:0] PRE_ZERO   = 7'h00;

  // dma and threshold field positions
  localparam int unsigned LVL_W          = 6;
  localparam int unsigned DMA_TX_EN_BIT  = 0;
  localparam int unsigned DMA_RX_EN_BIT  = 1;
  localparam int unsigned DMA_TX_LVL_LSB = 8;
  localparam int unsigned DMA_RX_LVL_LSB = 16;
  localparam int unsigned THR_RX_LSB     = 0;
  localparam int unsigned THR_TX_LSB     = 8;
  localparam logic [LVL_W-1:0] LVL_RESET = 6'h00;

  // status field positions
  localparam int unsigned ST_RX_EMPTY   = 4;
  localparam int unsigned ST_RX_FULL    = 5;
  localparam int unsigned ST_TX_EMPTY   = 6;
  localparam int unsigned ST_TX_FULL    = 7;
  localparam int unsigned ST_RX_NUM_LSB = 8;
  localparam int unsigned ST_TX_NUM_LSB = 16;

  // peek answer when nothing waits to go out
  localparam logic [DATA_W-1:0] PEEK_EMPTY = 8'h00;

  // bus answer sequencer
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ufb_bus_e;

endpackage

// >>> ufb_remote.sv
/* ufb_remote: far serial side, strobes received frames in, takes bytes.
   assumes: bench calls frame() and sets stall; clk is the block clock. */
`timescale 1ns/100ps
module ufb_remote
  import ufb_pkg::*;
(
  // clock
  input  wire logic              clk,
  // received frames
  output logic                   rx_valid,
  output logic [DATA_W-1:0]      rx_data,
  output logic                   rx_parity_err,
  output logic                   rx_frame_err,
  output logic                   rx_break,
  output logic                   rx_timeout,
  // transmit handshake
  input  wire logic              tx_valid,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic                   tx_ready
);
  logic              stall = 1'b1; // line busy until bench frees it
  logic [DATA_W-1:0] got[$];       // bytes taken off the block
  initial {rx_timeout, rx_break, rx_frame_err, rx_parity_err} = 4'h0;
  initial {rx_valid, rx_data} = 9'h000;
  assign tx_ready = !stall;
  // sampled mid-cycle, so the pop edge cannot race the capture
  always @(negedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // one event: {timeout, break, frame, parity, byte}; break and byte
  // are never sent together
  task automatic frame(input logic [DATA_W-1:0] d, input logic [4:0] k);
    @(posedge clk);
    {rx_timeout, rx_break, rx_frame_err, rx_parity_err, rx_valid} <= k;
    rx_data <= d;
    @(posedge clk);
    {rx_timeout, rx_break, rx_frame_err, rx_parity_err, rx_valid} <= 5'h00;
    rx_data <= ~d; // a stale byte never lingers
  endtask
endmodule // ufb_remote

// >>> ufb_top.sv
/*
  ufb_top: interrupt flags, bit-rate divisor, data window with 32-byte
  receive and transmit fifos, level-triggered dma requests and a transmit
  peek register, behind an avalon-mm slave with waitrequest.
  assumes: the serial receiver and transmitter run on clk and talk through
  the strobe ports below; cts arrives from a pin; master follows avalon.
*/
// Added by the designer: the Avalon-MM slave port.
// Behaviour
// - flag the last break frame of a run
// - flag the first break frame of a run
// - flag a receive frame timeout
// - flag transmit count at or above threshold
// - flag exactly one byte left to send
// - flag receive count at or above threshold
// - receive threshold flag re-sets while level holds
// - flag overrun when byte meets full fifo
// - parity flag from received data only
// - flags clear on write one, reset zero
// - three-bit code divides by 128 down to 8
// - twelve-bit integer divisor, read/write, reset zero
// - twelve-bit fraction divisor, read/write, reset zero
// - data window read pops, write pushes
// - rx dma requests above level until empty
// - tx dma requests below level until full
// - dma enables at bits one and zero
// - peek shows next byte, zero when empty
// - flag any change of cts level once the synchroniser is primed
`timescale 1ns/100ps
module ufb_top
  import ufb_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [WORD_W-1:0]   writedata,
  input  wire logic [3:0]          byteenable,
  output logic      [WORD_W-1:0]   readdata,
  output logic                     waitrequest,
  // receiver strobes
  input  wire logic                rx_valid,
  input  wire logic [DATA_W-1:0]   rx_data,
  input  wire logic                rx_parity_err,
  input  wire logic                rx_frame_err,
  input  wire logic                rx_break,
  input  wire logic                rx_timeout,
  // transmitter handshake
  output logic                     tx_valid,
  output logic      [DATA_W-1:0]   tx_data,
  input  wire logic                tx_ready,
  // modem pin
  input  wire logic                cts_pin,
  // bit-rate outputs
  output logic                     bit_rate_tick,
  output logic      [BAUD_W-1:0]   baud_integer,
  output logic      [BAUD_W-1:0]   baud_fraction,
  // dma and interrupt
  output logic                     rx_dma_req,
  output logic                     tx_dma_req,
  output logic                     irq
);

  // bus sequencer and captured read
  ufb_bus_e               bus_r;
  logic [WORD_W-1:0]      readdata_r;
  logic                   pop_ok_r;      // head was valid at capture
  logic [WORD_W-1:0]      rd_mux;
  logic [WORD_W-1:0]      wmask;
  logic [ADDR_W-1:0]      waddr;         // word-aligned address
  logic                   req;
  logic                   done;          // edge at which access completes
  logic                   wr_done;

  // software registers
  logic [FL_W-1:0]        flags_r;
  logic [FL_W-1:0]        int_en_r;
  logic [FL_W-1:0]        fl_set;
  logic [FL_W-1:0]        fl_clr;
  logic [BAUD_W-1:0]      baud_int_r;
  logic [BAUD_W-1:0]      baud_frac_r;
  logic [CLKDIV_W-1:0]    clkdiv_r;
  logic [LVL_W-1:0]       rx_thr_r;
  logic [LVL_W-1:0]       tx_thr_r;
  logic [LVL_W-1:0]       rxdma_lvl_r;
  logic [LVL_W-1:0]       txdma_lvl_r;
  logic                   rxdma_en_r;
  logic                   txdma_en_r;

  // fifo storage and pointers
  logic [DATA_W-1:0]      rx_mem [FIFO_DEPTH];
  logic [DATA_W-1:0]      tx_mem [FIFO_DEPTH];
  logic [PTR_W:0]         rx_wp_r;
  logic [PTR_W:0]         rx_rp_r;
  logic [PTR_W:0]         tx_wp_r;
  logic [PTR_W:0]         tx_rp_r;
  logic [CNT_W-1:0]       rx_cnt;
  logic [CNT_W-1:0]       tx_cnt;
  logic                   rx_full;
  logic                   rx_empty;
  logic                   tx_full;
  logic                   tx_empty;
  logic                   rx_push;
  logic                   rx_pop;
  logic                   tx_push;
  logic                   tx_pop;
  logic [DATA_W-1:0]      tx_head;

  // line events
  logic                   in_break_r;    // inside a run of break frames
  logic                   cts_meta_r;
  logic                   cts_sync_r;
  logic                   cts_prev_r;
  logic [2:0]             cts_warm_r;    // ignore change until primed
  logic [PRE_W-1:0]       pre_cnt_r;
  logic [PRE_W-1:0]       pre_reload;
  logic                   bit_tick_r;
  logic                   rx_dma_r;
  logic                   tx_dma_r;

  // decode helpers
  assign req     = read | write;
  assign done    = (bus_r == BUS_ACK) & req;
  assign wr_done = done & write;
  assign waddr   = {address[ADDR_W-1:2], 2'b00};
  assign wmask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  // one wait cycle per access: request, then answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: if (req) bus_r <= BUS_ACK;
        BUS_ACK:  bus_r <= BUS_IDLE;
        default:  bus_r <= BUS_IDLE;
      endcase
    end
  end

  assign waitrequest = (bus_r != BUS_ACK);
  assign readdata    = readdata_r;

  // read multiplexer; reserved bits and unmapped words read zero
  always_comb begin
    rd_mux = WORD_ZERO;
    if (waddr == OFF_THRESH) begin
      rd_mux[THR_RX_LSB +: LVL_W] = rx_thr_r;
      rd_mux[THR_TX_LSB +: LVL_W] = tx_thr_r;
    end else if (waddr == OFF_STATUS) begin
      rd_mux[ST_RX_EMPTY]              = rx_empty;
      rd_mux[ST_RX_FULL]               = rx_full;
      rd_mux[ST_TX_EMPTY]              = tx_empty;
      rd_mux[ST_TX_FULL]               = tx_full;
      rd_mux[ST_RX_NUM_LSB +: CNT_W]   = rx_cnt;
      rd_mux[ST_TX_NUM_LSB +: CNT_W]   = tx_cnt;
    end else if (waddr == OFF_INT_EN) begin
      rd_mux[FL_W-1:0] = int_en_r;
    end else if (waddr == OFF_INT_FL) begin
      rd_mux[FL_W-1:0] = flags_r;
    end else if (waddr == OFF_BAUD_INT) begin
      rd_mux[BAUD_LSB +: BAUD_W]     = baud_int_r;
      rd_mux[CLKDIV_LSB +: CLKDIV_W] = clkdiv_r;
    end else if (waddr == OFF_BAUD_FRAC) begin
      rd_mux[BAUD_LSB +: BAUD_W] = baud_frac_r;
    end else if (waddr == OFF_DATA) begin
      // empty fifo reads zero and pops nothing
      if (!rx_empty) rd_mux[DATA_W-1:0] = rx_mem[rx_rp_r[PTR_W-1:0]];
    end else if (waddr == OFF_DMA) begin
      rd_mux[DMA_TX_EN_BIT]            = txdma_en_r;
      rd_mux[DMA_RX_EN_BIT]            = rxdma_en_r;
      rd_mux[DMA_TX_LVL_LSB +: LVL_W]  = txdma_lvl_r;
      rd_mux[DMA_RX_LVL_LSB +: LVL_W]  = rxdma_lvl_r;
    end else if (waddr == OFF_PEEK) begin
      rd_mux[DATA_W-1:0] = tx_head;
    end else begin
      rd_mux = WORD_ZERO;
    end
  end

  // capture read data at the request edge so it stands in the answer cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_r <= WORD_ZERO;
      pop_ok_r   <= 1'b0;
    end else if ((bus_r == BUS_IDLE) && read) begin
      readdata_r <= rd_mux;
      pop_ok_r   <= (waddr == OFF_DATA) & ~rx_empty;
    end
  end

  // configuration writes, byte lanes honoured
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_thr_r    <= LVL_RESET;
      tx_thr_r    <= LVL_RESET;
      int_en_r    <= FL_RESET;
      baud_int_r  <= BAUD_RESET;
      clkdiv_r    <= CLKDIV_RESET;
      baud_frac_r <= BAUD_RESET;
      rxdma_lvl_r <= LVL_RESET;
      txdma_lvl_r <= LVL_RESET;
      rxdma_en_r  <= 1'b0;
      txdma_en_r  <= 1'b0;
    end else if (wr_done) begin
      if (waddr == OFF_THRESH) begin
        rx_thr_r <= (writedata[THR_RX_LSB +: LVL_W] & wmask[THR_RX_LSB +: LVL_W])
                  | (rx_thr_r & ~wmask[THR_RX_LSB +: LVL_W]);
        tx_thr_r <= (writedata[THR_TX_LSB +: LVL_W] & wmask[THR_TX_LSB +: LVL_W])
                  | (tx_thr_r & ~wmask[THR_TX_LSB +: LVL_W]);
      end else if (waddr == OFF_INT_EN) begin
        int_en_r <= (writedata[FL_W-1:0] & wmask[FL_W-1:0])
                  | (int_en_r & ~wmask[FL_W-1:0]);
      end else if (waddr == OFF_BAUD_INT) begin
        baud_int_r <= (writedata[BAUD_LSB +: BAUD_W] & wmask[BAUD_LSB +: BAUD_W])
                    | (baud_int_r & ~wmask[BAUD_LSB +: BAUD_W]);
        if (byteenable[2]) clkdiv_r <= writedata[CLKDIV_LSB +: CLKDIV_W];
      end else if (waddr == OFF_BAUD_FRAC) begin
        baud_frac_r <= (writedata[BAUD_LSB +: BAUD_W] & wmask[BAUD_LSB +: BAUD_W])
                     | (baud_frac_r & ~wmask[BAUD_LSB +: BAUD_W]);
      end else if (waddr == OFF_DMA) begin
        if (byteenable[0]) begin
          txdma_en_r <= writedata[DMA_TX_EN_BIT];
          rxdma_en_r <= writedata[DMA_RX_EN_BIT];
        end
        if (byteenable[1]) txdma_lvl_r <= writedata[DMA_TX_LVL_LSB +: LVL_W];
        if (byteenable[2]) rxdma_lvl_r <= writedata[DMA_RX_LVL_LSB +: LVL_W];
      end
    end
  end

  // fifo occupancy; extra pointer bit tells full from empty
  assign rx_cnt   = CNT_W'(rx_wp_r - rx_rp_r);
  assign tx_cnt   = CNT_W'(tx_wp_r - tx_rp_r);
  assign rx_full  = (rx_cnt == FIFO_FULL_CNT);
  assign tx_full  = (tx_cnt == FIFO_FULL_CNT);
  assign rx_empty = (rx_cnt == CNT_ZERO);
  assign tx_empty = (tx_cnt == CNT_ZERO);

  // push and pop strobes
  assign rx_push = rx_valid & ~rx_full;       // byte on a full fifo is lost
  assign rx_pop  = done & read & pop_ok_r;
  assign tx_push = wr_done & (waddr == OFF_DATA) & byteenable[0]
                 & ~tx_full;
  assign tx_pop  = tx_ready & ~tx_empty;

  // peek never moves a pointer
  assign tx_head  = tx_empty ? PEEK_EMPTY : tx_mem[tx_rp_r[PTR_W-1:0]];
  assign tx_valid = ~tx_empty;
  assign tx_data  = tx_mem[tx_rp_r[PTR_W-1:0]];

  // storage has no reset; pointers define what is valid
  always_ff @(posedge clk) begin
    if (rx_push) rx_mem[rx_wp_r[PTR_W-1:0]] <= rx_data;
    if (tx_push) tx_mem[tx_wp_r[PTR_W-1:0]] <= writedata[DATA_W-1:0];
  end

  // receive pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else begin
      if (rx_push) rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_pop)  rx_rp_r <= rx_rp_r + 1'b1;
    end
  end

  // transmit pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end else begin
      if (tx_push) tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop)  tx_rp_r <= tx_rp_r + 1'b1;
    end
  end

  // break run tracking: a break frame starts or continues the run, a data byte ends it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_break_r <= 1'b0;
    end else if (rx_valid | rx_break) begin
      in_break_r <= rx_break;
    end
  end

  // cts synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_meta_r <= 1'b0;
      cts_sync_r <= 1'b0;
      cts_prev_r <= 1'b0;
      cts_warm_r <= 3'h0;
    end else begin
      cts_meta_r <= cts_pin;
      cts_sync_r <= cts_meta_r;
      cts_prev_r <= cts_sync_r;
      cts_warm_r <= {cts_warm_r[1:0], 1'b1};
    end
  end

  // event sources for the sticky flags
  always_comb begin
    fl_set                = FL_RESET;
    fl_set[FL_LAST_BREAK] = in_break_r & rx_valid & ~rx_break;
    fl_set[FL_BREAK]      = rx_break & ~in_break_r;
    fl_set[FL_RECEIVE_TIMEOUT_FLAG]      = rx_timeout;
    fl_set[FL_TX_LVL]     = (tx_cnt >= tx_thr_r);
    fl_set[FL_TX_AE]      = (tx_cnt == CNT_ONE);
    // level based: clearing while still above threshold re-sets it
    fl_set[FL_RX_LVL]     = (rx_cnt >= rx_thr_r);
    fl_set[FL_RX_OVR]     = rx_valid & rx_full;
    fl_set[FL_PARITY]     = rx_valid & rx_parity_err;
    fl_set[FL_FRAME]      = rx_frame_err;
    fl_set[FL_CTS]        = cts_warm_r[2] & (cts_sync_r ^ cts_prev_r);
  end

  // write-one-to-clear mask from the flag register access
  assign fl_clr = (wr_done && (waddr == OFF_INT_FL))
                ? (writedata[FL_W-1:0] & wmask[FL_W-1:0]) : FL_RESET;

  // sticky flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= FL_RESET;
    end else begin
      flags_r <= (flags_r & ~fl_clr) | fl_set;
    end
  end

  // interrupt request from enabled flags
  assign irq = |(flags_r & int_en_r);

  // prescaler reload per divisor code; reserved codes fall back to 128
  always_comb begin
    case (clkdiv_r)
      CLKDIV_128: pre_reload = PRE_128_M1;
      CLKDIV_64:  pre_reload = PRE_64_M1;
      CLKDIV_32:  pre_reload = PRE_32_M1;
      CLKDIV_16:  pre_reload = PRE_16_M1;
      CLKDIV_8:   pre_reload = PRE_8_M1;
      default:    pre_reload = PRE_128_M1;
    endcase
  end

  // bit-rate prescaler: one-cycle tick per divided period
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_r  <= PRE_ZERO;
      bit_tick_r <= 1'b0;
    end else if (pre_cnt_r >= pre_reload) begin
      // a code change that leaves the count at or past the new reload restarts at once
      pre_cnt_r  <= PRE_ZERO;
      bit_tick_r <= 1'b1;
    end else begin
      pre_cnt_r  <= pre_cnt_r + 1'b1;
      bit_tick_r <= 1'b0;
    end
  end

  assign bit_rate_tick = bit_tick_r;
  assign baud_integer  = baud_int_r;
  assign baud_fraction = baud_frac_r;

  // receive dma: starts above level, holds until fifo drained
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_dma_r <= 1'b0;
    end else if (!rxdma_en_r) begin
      rx_dma_r <= 1'b0;
    end else if (rx_dma_r) begin
      rx_dma_r <= ~rx_empty;
    end else begin
      rx_dma_r <= (rx_cnt > rxdma_lvl_r);
    end
  end

  // transmit dma: starts below level, holds until fifo full
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_dma_r <= 1'b0;
    end else if (!txdma_en_r) begin
      tx_dma_r <= 1'b0;
    end else if (tx_dma_r) begin
      tx_dma_r <= ~tx_full;
    end else begin
      tx_dma_r <= (tx_cnt < txdma_lvl_r);
    end
  end

  assign rx_dma_req = rx_dma_r;
  assign tx_dma_req = tx_dma_r;

endmodule // ufb_top

// >>> ufb_top_asserts.sv
/* ufb_top_asserts: port-level checks on the flag and fifo block.
   assumes: bound to ufb_top; one clock, async active-low reset. */
`timescale 1ns/100ps
module ufb_top_asserts
  import ufb_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [WORD_W-1:0] writedata,
  input wire logic [3:0]        byteenable,
  input wire logic [WORD_W-1:0] readdata,
  input wire logic              waitrequest,
  // transmit, bit-rate and dma
  input wire logic              tx_valid,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic              tx_ready,
  input wire logic              bit_rate_tick,
  input wire logic [BAUD_W-1:0] baud_integer,
  input wire logic              rx_dma_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // word decode: the low address bits are ignored
  wire logic [3:0]        wa  = address[5:2];
  wire logic              dn  = (read || write) && !waitrequest;
  wire logic [BAUD_W-1:0] wbi = writedata[11:0]; // integer lanes
  property p_ack; (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no bus answer");
  property p_push; dn && write && wa == OFF_DATA[5:2] && byteenable[0]
    |=> tx_valid; endproperty
  a_push: assert property (p_push) else $error("push lost");
  // a stalled head may not move, even while pushes land behind it
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("head moved");
  property p_peek; dn && read && wa == OFF_PEEK[5:2] |-> readdata ==
    {24'h000000, $past(tx_valid) ? $past(tx_data) : PEEK_EMPTY};
  endproperty
  a_peek: assert property (p_peek) else $error("peek value");
  property p_resv; dn && read && wa == OFF_INT_FL[5:2]
    |-> readdata[31:10] == 22'h000000; endproperty
  a_resv: assert property (p_resv) else $error("flag spare bits");
  property p_int; dn && write && wa == OFF_BAUD_INT[5:2] &&
    byteenable == 4'hF |=> baud_integer == $past(wbi); endproperty
  a_int: assert property (p_int) else $error("divisor not held");
  // the fastest code divides by 8, so ticks stand 8 apart at least
  property p_tick; bit_rate_tick |=> (!bit_rate_tick) [*7]; endproperty
  a_tick: assert property (p_tick) else $error("tick too soon");
  property p_rxoff; dn && write && wa == OFF_DMA[5:2] && byteenable[0] &&
    !writedata[1] |=> ##1 !rx_dma_req; endproperty
  a_rxoff: assert property (p_rxoff) else $error("rx dma on");
endmodule // ufb_top_asserts
bind ufb_top ufb_top_asserts u_chk (.clk, .arst_n, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .tx_valid, .tx_data,
  .tx_ready, .bit_rate_tick, .baud_integer, .rx_dma_req);

// >>> ufb_top_test.sv
/* ufb_top_test: self-checking bench for flags, divisor, data window,
   dma and peek. assumes: ufb_remote stands on the serial side. */
`timescale 1ns/100ps
module ufb_top_test;
  import ufb_pkg::*;
  // bus master side
  logic              clk = 1'b0, arst_n = 1'b0, cts_pin = 1'b0;
  logic              read = 1'b0, write = 1'b0, waitrequest;
  logic [ADDR_W-1:0] address = 6'h00;
  logic [WORD_W-1:0] writedata = 32'h0, readdata, rd;
  logic [3:0]        byteenable = 4'hF; // whole words only
  // serial side and outputs
  logic              rx_valid, rx_parity_err, rx_frame_err, rx_break;
  logic              rx_timeout, tx_valid, tx_ready, bit_rate_tick;
  logic              rx_dma_req, tx_dma_req, irq;
  logic [DATA_W-1:0] rx_data, tx_data;
  logic [BAUD_W-1:0] baud_integer, baud_fraction;
  int                fails = 0, checks = 0;
  ufb_top dut (.clk, .arst_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .rx_valid, .rx_data,
    .rx_parity_err, .rx_frame_err, .rx_break, .rx_timeout, .tx_valid,
    .tx_data, .tx_ready, .cts_pin, .bit_rate_tick, .baud_integer,
    .baud_fraction, .rx_dma_req, .tx_dma_req, .irq);
  ufb_remote far (.clk, .rx_valid, .rx_data, .rx_parity_err, .rx_frame_err,
    .rx_break, .rx_timeout, .tx_valid, .tx_data, .tx_ready);
  initial forever #50 clk = ~clk; // 10 MHz
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // a spent wait bound ends the run as a mismatch
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      finish_test();
    end
  endtask
  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input int d);
    int n = 0;
    @(posedge clk);
    address <= a; writedata <= d; write <= w; read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0 && ++n < 20);
    tmo(n, 20);
    rd = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 0);
    cmp(rd, e);
  endtask
  // clocks from one bit-rate tick to the next
  task automatic gap(output int g);
    int n = 0;
    do @(negedge clk); while (bit_rate_tick !== 1'b1 && ++n < 300);
    g = 0;
    do begin @(negedge clk); g++; end while (!bit_rate_tick && g < 300);
    tmo(n + g, 300);
  endtask
  task automatic t_reset();
    rdc(OFF_INT_FL, 32'h50);
    rdc(OFF_BAUD_INT, WORD_ZERO);
    rdc(OFF_BAUD_FRAC, WORD_ZERO);
    rdc(OFF_DMA, WORD_ZERO);
    rdc(OFF_PEEK, WORD_ZERO);
    rdc(6'h3C, WORD_ZERO); // unmapped word
  endtask
  task automatic t_baud();
    int g;
    bus(1'b1, OFF_BAUD_INT, 32'hFFFF_FABC);
    rdc(OFF_BAUD_INT, 32'h0007_0ABC);
    bus(1'b1, OFF_BAUD_FRAC, 32'hFFFF_FFFF);
    rdc(OFF_BAUD_FRAC, 32'h0000_0FFF);
    cmp(32'(baud_fraction), 32'hFFF);
    for (int c = 0; c < 6; c++) begin // code 5 is spare: divides by 128
      bus(1'b1, OFF_BAUD_INT, c << 16);
      gap(g);
      cmp(g, c > 4 ? 128 : 128 >> c);
    end
  endtask
  task automatic t_flags();
    bus(1'b1, OFF_THRESH, 32'h2020); // both thresholds at 32
    bus(1'b1, OFF_INT_FL, 32'h3FF);
    far.frame(8'h00, 5'h08); // two break frames in a run
    far.frame(8'h00, 5'h08);
    far.frame(8'hA5, 5'h01); // data closes the run
    far.frame(8'h00, 5'h10); // timeout
    far.frame(8'h00, 5'h04); // framing fault
    far.frame(8'h3C, 5'h03); // byte with parity fault
    rdc(OFF_INT_FL, 32'h383);
    bus(1'b1, OFF_INT_FL, WORD_ZERO);
    rdc(OFF_INT_FL, 32'h383);
    bus(1'b1, OFF_INT_FL, 32'h3FF);
    rdc(OFF_INT_FL, WORD_ZERO);
    bus(1'b1, OFF_THRESH, 32'h2002); // rx threshold 2, level reached
    bus(1'b1, OFF_INT_FL, 32'h010);
    rdc(OFF_INT_FL, 32'h010);
    rdc(OFF_DATA, 32'hA5);
    bus(1'b1, OFF_INT_FL, 32'h010);
    rdc(OFF_INT_FL, WORD_ZERO);
    rdc(OFF_DATA, 32'h3C);
  endtask
  task automatic t_rx();
    for (int i = 0; i < 33; i++) far.frame(8'(i), 5'h01);
    bus(1'b0, OFF_INT_FL, 0);
    cmp(rd & 32'h8, 32'h8);
    bus(1'b1, OFF_DMA, 32'h0002_0002); // level 2, never 32
    rdc(OFF_DMA, 32'h0002_0002);
    cmp(32'(rx_dma_req), 32'h1);
    for (int i = 0; i < 32; i++) begin // last sent byte was lost
      if (i == 31) cmp(32'(rx_dma_req), 32'h1);
      rdc(OFF_DATA, i);
    end
    rdc(OFF_DATA, WORD_ZERO);
    cmp(32'(rx_dma_req), 32'h0);
    bus(1'b1, OFF_DMA, WORD_ZERO);
  endtask
  task automatic t_tx();
    int n = 0;
    bus(1'b1, OFF_INT_FL, 32'h3FF);
    bus(1'b1, OFF_DMA, 32'h0201); // tx level 2; a level of 0 would never request
    rdc(OFF_PEEK, WORD_ZERO);
    cmp(32'(tx_dma_req), 32'h1);
    bus(1'b1, OFF_DATA, 32'h11);
    rdc(OFF_INT_FL, 32'h20);
    for (int i = 1; i < 33; i++) bus(1'b1, OFF_DATA, 32'h11 + i);
    cmp(32'(tx_dma_req), 32'h0);
    rdc(OFF_INT_FL, 32'h60);
    rdc(OFF_PEEK, 32'h11);
    far.stall <= 1'b0;
    while (tx_valid !== 1'b0 && n++ < 100) @(negedge clk);
    tmo(n, 100);
    cmp(32'(far.got.size()), 32'h20);
    for (int i = 0; i < 32; i++) cmp(32'(far.got[i]), 32'h11 + i);
    rdc(OFF_PEEK, WORD_ZERO);
  endtask
  task automatic t_cts();
    bus(1'b1, OFF_DMA, WORD_ZERO);
    bus(1'b1, OFF_INT_FL, 32'h3FF);
    bus(1'b1, OFF_INT_EN, 32'h004);
    cmp(32'(irq), 32'h0);
    cts_pin <= 1'b1;
    bus(1'b0, OFF_INT_FL, 0); // lets the pin cross its synchroniser
    rdc(OFF_INT_FL, 32'h004);
    cmp(32'(irq), 32'h1);
    bus(1'b1, OFF_INT_FL, 32'h004);
    @(negedge clk);
    cmp(32'(irq), 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_baud();
    t_flags();
    t_rx();
    t_tx();
    t_cts();
    finish_test();
  end
endmodule // ufb_top_test
